//--- hw/id_page_pkg.sv
// Package with register map, field layout and bus constants of the identification and page block
package id_page_pkg;

   // Register indices as printed; byte address is four times the index
   localparam logic [5:0] LOT_LOW_IDX   = 6'h2B;
   localparam logic [5:0] UID_HIGH_IDX  = 6'h2C;
   localparam logic [5:0] UID_LOW_IDX   = 6'h2D;
   localparam logic [5:0] WAFER_IDX     = 6'h2E;
   localparam logic [5:0] RAM_PAGE_IDX  = 6'h3F;

   localparam int ADDR_WIDTH = 8;
   localparam int DATA_WIDTH = 32;

   // Page register fields
   localparam int PAGE_LEAK_BIT   = 7;
   localparam int PAGE_POL_BIT    = 6;
   localparam int PAGE_WDT_BIT    = 5;
   localparam int PAGE_UNUSED_BIT = 4;
   localparam int PAGE_RSVD_BIT   = 3;
   localparam int PAGE_ALT_BIT    = 2;
   localparam int PAGE_STD_LSB    = 0;
   localparam logic [7:0] PAGE_RESET      = 8'h00;
   localparam logic [7:0] PAGE_WRITE_MASK = 8'hCF;

   // Identification field positions
   localparam int UID_HIGH_LOT_BIT = 7;
   localparam int WAFER_LOT_BIT    = 7;
   localparam int WAFER_NUM_LSB    = 1;

   // RAM windows
   localparam logic [1:0] STD_WINDOW_TAG = 2'h1;
   localparam int         STD_OFFS_BITS  = 6;
   localparam int         ALT_OFFS_BITS  = 7;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- hw/level_sync.sv
// Two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/10ps
module level_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clock,    // System clock
   input  wire logic             sys_rst,  // Async reset, active high
   input  wire logic [WIDTH-1:0] asyncIn,  // Level from a pin
   output logic      [WIDTH-1:0] syncOut   // Level safe to use
);

   logic [WIDTH-1:0] stage1_q;
   logic [WIDTH-1:0] stage2_q;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         stage1_q <= '0;
         stage2_q <= '0;
      end else begin
         stage1_q <= asyncIn;
         stage2_q <= stage1_q;
      end
   end

   assign syncOut = stage2_q;

endmodule // level_sync

//--- hw/id_and_ram_page_regs.sv
// Identification registers, RAM page register and RAM address former behind AXI4-Lite
`timescale 1ns/10ps
module id_and_ram_page_regs
   import id_page_pkg::*;
#(
   // Factory values; the defaults are arbitrary
   parameter logic [9:0]  LOT_NUMBER   = 10'h15A,
   parameter logic [14:0] PART_UID     = 15'h2C3D,
   parameter logic [5:0]  WAFER_NUMBER = 6'h13
) (
   input  wire logic                    clock,                // 100 MHz clock
   input  wire logic                    sys_rst,              // Async reset, active high
   input  wire logic [ADDR_WIDTH-1:0]   awaddr,               // Write address
   input  wire logic                    awvalid,              // Write address valid
   output logic                         awready,              // Write address ready
   input  wire logic [DATA_WIDTH-1:0]   wdata,                // Write data
   input  wire logic [3:0]              wstrb,                // Write byte strobes
   input  wire logic                    wvalid,               // Write data valid
   output logic                         wready,               // Write data ready
   output logic [1:0]                   bresp,                // Write response
   output logic                         bvalid,               // Write response valid
   input  wire logic                    bready,               // Write response ready
   input  wire logic [ADDR_WIDTH-1:0]   araddr,               // Read address
   input  wire logic                    arvalid,              // Read address valid
   output logic                         arready,              // Read address ready
   output logic [DATA_WIDTH-1:0]        rdata,                // Read data
   output logic [1:0]                   rresp,                // Read response
   output logic                         rvalid,               // Read data valid
   input  wire logic                    rready,               // Read data ready
   input  wire logic                    watchdog_input_pin,   // Watchdog pin, async
   input  wire logic                    backupBelowRef,       // Comparator: supply below ref
   input  wire logic                    batteryFlagClear,     // Clears the flag, one cycle
   output logic                         battery_low_flag,     // Sticky battery-low flag
   output logic                         leakPathConnect,      // Page bit seven as stored
   input  wire logic [7:0]              ramOffset,            // Register offset of a RAM access
   input  wire logic                    ramReq,               // RAM access strobe
   output logic [7:0]                   ramAddr,              // Effective RAM address
   output logic                         ramAddrValid,         // Address valid, one cycle
   output logic                         ramAltWindow          // Access hit alternate window
);

   logic [7:0]  page_q;
   logic        awHeld_q, wHeld_q, arBusy_q;
   logic        awReady_q, wReady_q, arReady_q;
   logic [5:0]  wrIdx_q;
   logic [7:0]  wrByte_q;
   logic        wrLane_q;
   logic        bValid_q, rValid_q;
   logic [1:0]  bResp_q, rResp_q;
   logic [7:0]  rData_q;
   logic        awHeldD, wHeldD, arBusyD;
   logic        wrFire, arFire;
   logic [1:0]  syncLevels;
   logic        wdtLevel, belowRef, belowPrev_q, flag_q, crossing;
   logic [7:0]  ramAddr_q;
   logic        ramValid_q, ramAlt_q;
   logic        leak_q;

   level_sync #(.WIDTH(2)) pinSync (
      .clock   (clock),
      .sys_rst (sys_rst),
      .asyncIn ({backupBelowRef, watchdog_input_pin}),
      .syncOut (syncLevels)
   );
   assign wdtLevel = syncLevels[0];
   assign belowRef = syncLevels[1];

   function automatic logic mapped(input logic [5:0] idx);
      mapped = (idx == LOT_LOW_IDX) || (idx == UID_HIGH_IDX) || (idx == UID_LOW_IDX) ||
               (idx == WAFER_IDX) || (idx == RAM_PAGE_IDX);
   endfunction

   // Read view; id contents are constants so no write can reach them
   function automatic logic [7:0] readView(input logic [5:0] idx, input logic [7:0] page,
                                           input logic wdt);
      logic [7:0] v;
      v = 8'h00;
      unique case (idx)
         LOT_LOW_IDX:  v = LOT_NUMBER[7:0];
         UID_HIGH_IDX: v = {LOT_NUMBER[9], PART_UID[14:8]};
         UID_LOW_IDX:  v = PART_UID[7:0];
         WAFER_IDX:    v = {LOT_NUMBER[8], WAFER_NUMBER, 1'b0};
         RAM_PAGE_IDX: begin
            v = page & PAGE_WRITE_MASK;
            v[PAGE_WDT_BIT] = wdt;
         end
         default:      v = 8'h00;
      endcase
      readView = v;
   endfunction

   // Write channel: address and data taken in either order
   assign wrFire  = awHeld_q && wHeld_q && !bValid_q;
   assign awHeldD = (awHeld_q && !(bValid_q && bready)) || (awvalid && awReady_q);
   assign wHeldD  = (wHeld_q && !(bValid_q && bready)) || (wvalid && wReady_q);

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         awHeld_q  <= 1'b0;
         wHeld_q   <= 1'b0;
         awReady_q <= 1'b0;
         wReady_q  <= 1'b0;
      end else begin
         awHeld_q  <= awHeldD;
         wHeld_q   <= wHeldD;
         awReady_q <= !awHeldD;
         wReady_q  <= !wHeldD;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         wrIdx_q  <= 6'h00;
         wrByte_q <= 8'h00;
         wrLane_q <= 1'b0;
      end else begin
         if (awvalid && awReady_q) begin
            wrIdx_q <= awaddr[7:2];
         end
         if (wvalid && wReady_q) begin
            wrByte_q <= wdata[7:0];
            wrLane_q <= wstrb[0];
         end
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         bValid_q <= 1'b0;
         bResp_q  <= RESP_OKAY;
      end else if (wrFire) begin
         bValid_q <= 1'b1;
         bResp_q  <= mapped(wrIdx_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bValid_q && bready) begin
         bValid_q <= 1'b0;
      end
   end

   // Only the writable page bits take data; bit seven is stored as written
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         page_q <= PAGE_RESET;
      end else if (wrFire && wrLane_q && (wrIdx_q == RAM_PAGE_IDX)) begin
         page_q <= wrByte_q & PAGE_WRITE_MASK;
      end
   end

   // Bit seven should be zero per host software; the device just drives it out
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         leak_q <= 1'b0;
      end else begin
         leak_q <= page_q[PAGE_LEAK_BIT];
      end
   end

   // Read channel: one read in flight, answer one cycle after the address
   assign arFire  = arvalid && arReady_q;
   assign arBusyD = arFire || (rValid_q && !rready);

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         arReady_q <= 1'b0;
         arBusy_q  <= 1'b0;
      end else begin
         arReady_q <= !arBusyD;
         arBusy_q  <= arBusyD;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rValid_q <= 1'b0;
         rData_q  <= 8'h00;
         rResp_q  <= RESP_OKAY;
      end else if (arFire) begin
         rValid_q <= 1'b1;
         rData_q  <= readView(araddr[7:2], page_q, wdtLevel);
         rResp_q  <= mapped(araddr[7:2]) ? RESP_OKAY : RESP_SLVERR;
      end else if (rValid_q && rready) begin
         rValid_q <= 1'b0;
      end
   end

   // Battery flag: the edge direction follows the polarity bit; set beats clear
   assign crossing = page_q[PAGE_POL_BIT] ? (belowPrev_q && !belowRef)
                                          : (!belowPrev_q && belowRef);

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         belowPrev_q <= 1'b0;
         flag_q      <= 1'b0;
      end else begin
         belowPrev_q <= belowRef;
         if (crossing) begin
            flag_q <= 1'b1;
         end else if (batteryFlagClear) begin
            flag_q <= 1'b0;
         end
      end
   end

   // RAM address former; offsets below the windows give no address
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         ramAddr_q  <= 8'h00;
         ramValid_q <= 1'b0;
         ramAlt_q   <= 1'b0;
      end else begin
         ramValid_q <= ramReq && (ramOffset[7] || (ramOffset[7:6] == STD_WINDOW_TAG));
         ramAlt_q   <= ramOffset[7];
         if (ramOffset[7]) begin
            ramAddr_q <= {page_q[PAGE_ALT_BIT], ramOffset[ALT_OFFS_BITS-1:0]};
         end else begin
            ramAddr_q <= {page_q[PAGE_STD_LSB +: 2], ramOffset[STD_OFFS_BITS-1:0]};
         end
      end
   end

   assign awready          = awReady_q;
   assign wready           = wReady_q;
   assign bvalid           = bValid_q;
   assign bresp            = bResp_q;
   assign arready          = arReady_q;
   assign rvalid           = rValid_q;
   assign rresp            = rResp_q;
   assign rdata            = {24'h000000, rData_q};
   assign battery_low_flag = flag_q;
   assign leakPathConnect  = leak_q;
   assign ramAddr          = ramAddr_q;
   assign ramAddrValid     = ramValid_q;
   assign ramAltWindow     = ramAlt_q;

   sequence readOf(logic [5:0] idx);
      arvalid && arready && (araddr[7:2] == idx);
   endsequence

   lot_low_read_a: assert property (@(posedge clock) disable iff (sys_rst)
      readOf(LOT_LOW_IDX) |=> rvalid && (rdata[7:0] == LOT_NUMBER[7:0]))
      else $error("lot low read wrong");

   uid_high_lot_a: assert property (@(posedge clock) disable iff (sys_rst)
      readOf(UID_HIGH_IDX) |=> rdata[UID_HIGH_LOT_BIT] == LOT_NUMBER[9])
      else $error("uid high lot bit wrong");

   uid_high_id_a: assert property (@(posedge clock) disable iff (sys_rst)
      readOf(UID_HIGH_IDX) |=> (rdata[6:0] == PART_UID[14:8]) && (rdata[31:8] == 24'h000000))
      else $error("uid high id bits wrong");

   uid_assembly_a: assert property (@(posedge clock) disable iff (sys_rst)
      readOf(UID_LOW_IDX) ##1 (rvalid && rready) ##[1:8] readOf(UID_HIGH_IDX) |=>
      ({rdata[6:0], $past(rdata[7:0], 1)} == PART_UID))
      else $error("part id assembly wrong");

   uid_low_read_a: assert property (@(posedge clock) disable iff (sys_rst)
      readOf(UID_LOW_IDX) |=> rdata[7:0] == PART_UID[7:0])
      else $error("uid low read wrong");

   wafer_read_a: assert property (@(posedge clock) disable iff (sys_rst)
      readOf(WAFER_IDX) |=> rdata[7:0] == {LOT_NUMBER[8], WAFER_NUMBER, 1'b0})
      else $error("wafer read wrong");

   id_write_ignored_a: assert property (@(posedge clock) disable iff (sys_rst)
      (wrFire && (wrIdx_q != RAM_PAGE_IDX)) |=> $stable(page_q) && bvalid)
      else $error("id write had effect");

   wdt_mirror_a: assert property (@(posedge clock) disable iff (sys_rst)
      readOf(RAM_PAGE_IDX) |=> rdata[PAGE_WDT_BIT] == $past(wdtLevel, 1))
      else $error("watchdog mirror wrong");

   unused_zero_a: assert property (@(posedge clock) disable iff (sys_rst)
      readOf(RAM_PAGE_IDX) |=> !rdata[PAGE_UNUSED_BIT] && !page_q[PAGE_WDT_BIT])
      else $error("unused bit not zero");

   flag_set_a: assert property (@(posedge clock) disable iff (sys_rst)
      (!page_q[PAGE_POL_BIT] && !belowPrev_q && belowRef) ##1 1'b1 |-> battery_low_flag)
      else $error("battery flag not set");

   flag_set_above_a: assert property (@(posedge clock) disable iff (sys_rst)
      (page_q[PAGE_POL_BIT] && belowPrev_q && !belowRef) |=> battery_low_flag)
      else $error("battery flag not set on rise above");

   alt_window_a: assert property (@(posedge clock) disable iff (sys_rst)
      (ramReq && ramOffset[7]) |=> ramAddrValid && ramAltWindow &&
      (ramAddr == {$past(page_q[PAGE_ALT_BIT], 1), $past(ramOffset[6:0], 1)}))
      else $error("alternate address wrong");

   std_window_a: assert property (@(posedge clock) disable iff (sys_rst)
      (ramReq && (ramOffset[7:6] == 2'h1)) |=>
      ramAddrValid && (ramAddr == {$past(page_q[1:0], 1), $past(ramOffset[5:0], 1)}))
      else $error("standard address wrong");

endmodule // id_and_ram_page_regs

//--- verif/id_and_ram_page_regs_tb.sv
// Self-checking bench for the identification and RAM page register block
`timescale 1ns/10ps
module id_and_ram_page_regs_tb;
   import id_page_pkg::*;
   // Factory values for this run; arbitrary
   localparam logic [9:0]  LOT = 10'h2A5;
   localparam logic [14:0] UID = 15'h5B3C;
   localparam logic [5:0]  WAF = 6'h2D;
   logic        clock, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, watchdog_input_pin, backupBelowRef;
   logic        batteryFlagClear, battery_low_flag, leakPathConnect;
   logic        ramReq, ramAddrValid, ramAltWindow;
   logic [7:0]  awaddr, araddr, ramOffset, ramAddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   int          fails = 0;
   int          comparisons = 0;
   int          cycles = 0;

   id_and_ram_page_regs #(.LOT_NUMBER(LOT), .PART_UID(UID), .WAFER_NUMBER(WAF)) dut_u (
      .clock(clock), .sys_rst(sys_rst), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .watchdog_input_pin(watchdog_input_pin),
      .backupBelowRef(backupBelowRef), .batteryFlagClear(batteryFlagClear),
      .battery_low_flag(battery_low_flag), .leakPathConnect(leakPathConnect),
      .ramOffset(ramOffset), .ramReq(ramReq), .ramAddr(ramAddr),
      .ramAddrValid(ramAddrValid), .ramAltWindow(ramAltWindow));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   function automatic logic [7:0] ra(input logic [5:0] idx);
      return {idx, 2'b00};
   endfunction

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic checkVal(input string what, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic checkBit(input string what, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %b seen %b", what, e, g);
      end
   endtask

   // Both channels offered together; each dropped at its own handshake
   task automatic busWrite(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                           output logic [1:0] r);
      logic done;
      done = 1'b0;
      @(posedge clock);
      awaddr  <= a;
      wdata   <= {24'h0, d};
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!done) begin
         @(posedge clock);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            done = 1'b1;
         end
      end
      bready <= 1'b0;
   endtask

   task automatic busRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic done;
      done = 1'b0;
      @(posedge clock);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (!done) begin
         @(posedge clock);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            r = rresp;
            done = 1'b1;
         end
      end
      rready <= 1'b0;
   endtask

   task automatic testIds;
      logic [5:0]  idx [4] = '{LOT_LOW_IDX, UID_HIGH_IDX, UID_LOW_IDX, WAFER_IDX};
      logic [7:0]  e [4] = '{LOT[7:0], {LOT[9], UID[14:8]}, UID[7:0], {LOT[8], WAF, 1'b0}};
      logic [31:0] d;
      logic [31:0] hi;
      logic [1:0]  r;
      for (int k = 0; k < 4; k++) begin
         busRead(ra(idx[k]), d, r);
         checkVal("id value", {24'h0, e[k]}, d);
         checkVal("id read resp", {30'h0, RESP_OKAY}, {30'h0, r});
         busWrite(ra(idx[k]), ~e[k], 4'h1, r);
         checkVal("id write resp", {30'h0, RESP_OKAY}, {30'h0, r});
         busRead(ra(idx[k]), d, r);
         checkVal("id after write", {24'h0, e[k]}, d);
      end
      // Low then high back to back, as software assembles the part id
      busRead(ra(UID_LOW_IDX), d, r);
      busRead(ra(UID_HIGH_IDX), hi, r);
      checkVal("part id", {17'h0, UID}, {17'h0, hi[6:0], d[7:0]});
      $display("id test done");
   endtask

   task automatic testPage;
      logic [31:0] d;
      logic [1:0]  r;
      busRead(ra(RAM_PAGE_IDX), d, r);
      checkVal("page reset", {24'h0, PAGE_RESET}, d);
      busWrite(ra(RAM_PAGE_IDX), 8'h7F, 4'h1, r);
      busRead(ra(RAM_PAGE_IDX), d, r);
      checkVal("page rw bits", 32'h0000004F, d);
      checkBit("leak path", 1'b0, leakPathConnect);
      busWrite(ra(RAM_PAGE_IDX), 8'h00, 4'h0, r);
      busRead(ra(RAM_PAGE_IDX), d, r);
      checkVal("page no strobe", 32'h0000004F, d);
      watchdog_input_pin <= 1'b1;
      repeat (4) @(posedge clock);
      busRead(ra(RAM_PAGE_IDX), d, r);
      checkVal("pin high", 32'h0000006F, d);
      watchdog_input_pin <= 1'b0;
      repeat (4) @(posedge clock);
      busRead(ra(RAM_PAGE_IDX), d, r);
      checkVal("pin low", 32'h0000004F, d);
      busWrite(8'h00, 8'h5A, 4'h1, r);
      checkVal("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, r});
      busRead(8'h00, d, r);
      checkVal("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      checkVal("unmapped data", 32'h0, d);
      // Second reset in mid-run: page clears, identification survives
      @(posedge clock);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      busRead(ra(RAM_PAGE_IDX), d, r);
      checkVal("page after reset", {24'h0, PAGE_RESET}, d);
      busRead(ra(LOT_LOW_IDX), d, r);
      checkVal("lot after reset", {24'h0, LOT[7:0]}, d);
      $display("page test done");
   endtask

   task automatic testRam;
      logic [7:0] pg [9] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h04, 8'h04, 8'h02, 8'h01};
      logic [7:0] of [9] = '{8'h40, 8'h7F, 8'h80, 8'hFF, 8'h3F, 8'h45, 8'h81, 8'h40, 8'h55};
      logic [7:0] ea [9] = '{8'hC0, 8'hFF, 8'h00, 8'h7F, 8'h00, 8'h05, 8'h81, 8'h80, 8'h55};
      logic [1:0] fl [9] = '{2'h1, 2'h1, 2'h3, 2'h3, 2'h0, 2'h1, 2'h3, 2'h1, 2'h1};
      logic [1:0] r;
      for (int k = 0; k < 9; k++) begin
         busWrite(ra(RAM_PAGE_IDX), pg[k], 4'h1, r);
         @(posedge clock);
         ramOffset <= of[k];
         ramReq    <= 1'b1;
         @(posedge clock);
         ramReq <= 1'b0;
         #1;
         checkBit("ram valid", fl[k][0], ramAddrValid);
         if (fl[k][0]) begin
            checkVal("ram addr", {24'h0, ea[k]}, {24'h0, ramAddr});
            checkBit("ram alt", fl[k][1], ramAltWindow);
         end
      end
      $display("ram test done");
   endtask

   // Comparator passes two flops and an edge detector; eight cycles is ample
   task automatic setSupply(input logic below, input logic e);
      @(posedge clock);
      backupBelowRef <= below;
      repeat (8) @(posedge clock);
      checkBit("battery flag", e, battery_low_flag);
   endtask

   task automatic clearFlag;
      @(posedge clock);
      batteryFlagClear <= 1'b1;
      @(posedge clock);
      batteryFlagClear <= 1'b0;
      repeat (2) @(posedge clock);
      checkBit("flag cleared", 1'b0, battery_low_flag);
   endtask

   // Clear pulse lands in the cycle the crossing is detected; set must win
   task automatic collide(input logic below);
      @(posedge clock);
      backupBelowRef <= below;
      repeat (2) @(posedge clock);
      batteryFlagClear <= 1'b1;
      @(posedge clock);
      batteryFlagClear <= 1'b0;
      repeat (2) @(posedge clock);
      checkBit("set beats clear", 1'b1, battery_low_flag);
   endtask

   task automatic testBattery;
      logic [1:0] r;
      busWrite(ra(RAM_PAGE_IDX), 8'h00, 4'h1, r);
      setSupply(1'b1, 1'b1);
      clearFlag();
      setSupply(1'b0, 1'b0);
      collide(1'b1);
      clearFlag();
      setSupply(1'b0, 1'b0);
      busWrite(ra(RAM_PAGE_IDX), 8'h40, 4'h1, r);
      setSupply(1'b1, 1'b0);
      setSupply(1'b0, 1'b1);
      clearFlag();
      $display("battery test done");
   endtask

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails++;
         give_verdict();
      end
   end

   initial begin
      sys_rst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, ramOffset} = 24'h000000;
      wdata = 32'h0;
      wstrb = 4'h0;
      {watchdog_input_pin, backupBelowRef, batteryFlagClear, ramReq} = 4'h0;
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      testIds();
      testPage();
      testRam();
      testBattery();
      give_verdict();
   end
endmodule // id_and_ram_page_regs_tb
